/* File: rtl/sram_port_regs.svh */
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// ==========================================================
// Word and bus geometry
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_WORD_W 36
`define SRAM_ADDR_W 19
`define BUS_ADDR_W 26
`define BUS_ADDR_LO 2
`define BUS_ADDR_HI 25
`define CTL_ADDR_W 24
`define PAR_LSB 32

// ==========================================================
// Latencies in memory clocks
`define READ_LAT 2
`define WRITE_LAT 1

// ==========================================================
// Clock rates
`define SYS_CLK_HZ 40000000
`define LINK_MAX_HZ 250000000
`define LINK_HALF_CYC 4
`define LINK_MIN_HALF_CYC 4

`endif

/* File: rtl/sram_port_pkg.sv */
package sram_port_pkg;

`include "sram_port_regs.svh"

    typedef logic [`SRAM_WORD_W-1:0] sram_word_t;
    typedef logic [`SRAM_LANES-1:0] lane_mask_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WDATA,
        ST_RWAIT1,
        ST_RWAIT2,
        ST_REL
    } ctl_state_t;

endpackage

/* File: rtl/shared_memory_bus_if.sv */
`timescale 1ns/1ps

`include "sram_port_regs.svh"

interface shared_memory_bus_if;
    logic sram_clock_pin;
    logic [`BUS_ADDR_W-1:0] shared_address_line;
    logic [`SRAM_DATA_W-1:0] ctl_data_o;
    logic ctl_data_oe_n;
    logic [`SRAM_LANES-1:0] ctl_par_o;
    logic [`SRAM_DATA_W-1:0] dev_data_o;
    logic dev_data_oe_n;
    logic [`SRAM_LANES-1:0] dev_par_o;
    logic [`SRAM_DATA_W-1:0] shared_data_line;
    logic [`SRAM_LANES-1:0] lane_parity_bit;
    logic output_enable_a_n;
    logic output_enable_b_n;
    logic chip_select_high;
    logic chip_select_low_n;
    logic burst_order_select;
    logic [`SRAM_LANES-1:0] lane_write_enable_n;
    logic byte_write_gate;
    logic whole_word_write_n;
    logic controller_addr_strobe_n;
    logic processor_addr_strobe_n;
    logic burst_advance_n;

    // ==========================================================
    // Wire level: a floating bus reads as zero
    assign shared_data_line = !ctl_data_oe_n ? ctl_data_o :
        (!dev_data_oe_n ? dev_data_o : 32'h0);
    assign lane_parity_bit = !ctl_data_oe_n ? ctl_par_o :
        (!dev_data_oe_n ? dev_par_o : 4'h0);

    modport ctl (
        output sram_clock_pin, shared_address_line, ctl_data_o,
        output ctl_data_oe_n, ctl_par_o, output_enable_a_n,
        output output_enable_b_n, chip_select_high, chip_select_low_n,
        output burst_order_select, lane_write_enable_n, byte_write_gate,
        output whole_word_write_n, controller_addr_strobe_n,
        output processor_addr_strobe_n, burst_advance_n,
        input shared_data_line, lane_parity_bit
    );

    modport dev (
        input sram_clock_pin, shared_address_line, output_enable_a_n,
        input output_enable_b_n, chip_select_high, chip_select_low_n,
        input burst_order_select, lane_write_enable_n, byte_write_gate,
        input whole_word_write_n, controller_addr_strobe_n,
        input processor_addr_strobe_n, burst_advance_n,
        input shared_data_line, lane_parity_bit,
        output dev_data_o, dev_data_oe_n, dev_par_o
    );
endinterface

/* File: rtl/sram_device_end.sv */
`timescale 1ns/1ps

`include "sram_port_regs.svh"

module sram_device_end
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    shared_memory_bus_if.dev bus,
    output logic access_strobe,
    output logic access_is_write
);

    localparam int IN_W = 1 + `CTL_ADDR_W + 14 + `SRAM_WORD_W;

    // ==========================================================
    // Pin synchronisers
    logic [IN_W-1:0] pin_s1_r, pin_s2_r;
    logic clk_prev_r;
    logic rise;
    logic s_clk, s_oe_a_n, s_oe_b_n, s_cs_hi, s_cs_lo_n, s_mode;
    logic s_bwe_n, s_gw_n, s_adsc_n, s_adsp_n, s_adv_n;
    logic [`SRAM_LANES-1:0] s_bw_n;
    logic [`CTL_ADDR_W-1:0] s_addr;
    sram_word_t s_word;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= {bus.sram_clock_pin,
                bus.shared_address_line[`BUS_ADDR_HI:`BUS_ADDR_LO],
                bus.output_enable_a_n, bus.output_enable_b_n,
                bus.chip_select_high, bus.chip_select_low_n,
                bus.burst_order_select, bus.lane_write_enable_n,
                bus.byte_write_gate, bus.whole_word_write_n,
                bus.controller_addr_strobe_n,
                bus.processor_addr_strobe_n, bus.burst_advance_n,
                bus.lane_parity_bit, bus.shared_data_line};
            pin_s2_r <= pin_s1_r;
            clk_prev_r <= s_clk;
        end
    end

    assign {s_clk, s_addr, s_oe_a_n, s_oe_b_n, s_cs_hi, s_cs_lo_n, s_mode,
        s_bw_n, s_bwe_n, s_gw_n, s_adsc_n, s_adsp_n, s_adv_n,
        s_word} = pin_s2_r;

    // Edge detect only; no timeout, so any slow clock is fine
    assign rise = s_clk & !clk_prev_r;

    // ==========================================================
    // Storage, 512K words of 36 bits
    sram_word_t mem [0:(1<<ADDR_W)-1];

    // ==========================================================
    // Access pipeline
    logic rd_pend_r, rd_pend_nxt, wr_pend_r, wr_pend_nxt;
    logic [ADDR_W-1:0] acc_addr_r, acc_addr_nxt;
    lane_mask_t wr_mask_r, wr_mask_nxt;
    logic [ADDR_W-1:0] base_r, base_nxt;
    logic [1:0] burst_cnt_r, burst_cnt_nxt;
    logic burst_rd_r, burst_rd_nxt;
    sram_word_t dout_r, dout_nxt;
    logic dout_valid_r, dout_valid_nxt;
    logic sel, is_wr;
    lane_mask_t mask;
    logic [1:0] step_cnt, step_lo;

    always_comb begin
        sel = s_cs_hi & !s_cs_lo_n & (!s_adsc_n | !s_adsp_n);
        // Global write takes all lanes, else gate picks lanes
        mask = !s_gw_n ? 4'hF : (!s_bwe_n ? ~s_bw_n : 4'h0);
        is_wr = mask != 4'h0;
        step_cnt = burst_cnt_r + 2'h1;
        step_lo = s_mode ? base_r[1:0] ^ step_cnt
                         : base_r[1:0] + step_cnt;
        rd_pend_nxt = rd_pend_r;
        wr_pend_nxt = wr_pend_r;
        acc_addr_nxt = acc_addr_r;
        wr_mask_nxt = wr_mask_r;
        base_nxt = base_r;
        burst_cnt_nxt = burst_cnt_r;
        burst_rd_nxt = burst_rd_r;
        dout_nxt = dout_r;
        dout_valid_nxt = dout_valid_r;
        if (rise) begin
            // Word out after the next edge, valid at the second
            dout_valid_nxt = rd_pend_r;
            if (rd_pend_r) begin
                dout_nxt = mem[acc_addr_r];
            end
            rd_pend_nxt = 1'b0;
            wr_pend_nxt = 1'b0;
            if (sel) begin
                acc_addr_nxt = s_addr[ADDR_W-1:0];
                base_nxt = s_addr[ADDR_W-1:0];
                burst_cnt_nxt = 2'h0;
                burst_rd_nxt = !is_wr;
                rd_pend_nxt = !is_wr;
                wr_pend_nxt = is_wr;
                wr_mask_nxt = mask;
            end else if (!s_adv_n) begin
                acc_addr_nxt = {base_r[ADDR_W-1:2], step_lo};
                burst_cnt_nxt = step_cnt;
                rd_pend_nxt = burst_rd_r;
                wr_pend_nxt = !burst_rd_r & (mask != 4'h0);
                wr_mask_nxt = mask;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_pend_r <= 1'b0;
            wr_pend_r <= 1'b0;
            acc_addr_r <= '0;
            wr_mask_r <= 4'h0;
            base_r <= '0;
            burst_cnt_r <= 2'h0;
            burst_rd_r <= 1'b0;
            dout_r <= '0;
            dout_valid_r <= 1'b0;
        end else begin
            rd_pend_r <= rd_pend_nxt;
            wr_pend_r <= wr_pend_nxt;
            acc_addr_r <= acc_addr_nxt;
            wr_mask_r <= wr_mask_nxt;
            base_r <= base_nxt;
            burst_cnt_r <= burst_cnt_nxt;
            burst_rd_r <= burst_rd_nxt;
            dout_r <= dout_nxt;
            dout_valid_r <= dout_valid_nxt;
        end
    end

    // Data of a write is taken one edge after its address
    always_ff @(posedge clk_sys) begin
        if (rise && wr_pend_r) begin
            for (int i = 0; i < `SRAM_LANES; i++) begin
                if (wr_mask_r[i]) begin
                    mem[acc_addr_r][8*i +: 8] <= s_word[8*i +: 8];
                    mem[acc_addr_r][`PAR_LSB+i] <=
                        s_word[`PAR_LSB+i];
                end
            end
        end
    end

    // ==========================================================
    // Pin drive: both output enables must be low
    assign bus.dev_data_oe_n =
        !(dout_valid_r & !s_oe_a_n & !s_oe_b_n);
    assign bus.dev_data_o = dout_r[`SRAM_DATA_W-1:0];
    assign bus.dev_par_o = dout_r[`SRAM_WORD_W-1:`PAR_LSB];
    assign access_strobe = rise & (rd_pend_r | wr_pend_r);
    assign access_is_write = wr_pend_r;

endmodule

/* File: rtl/sram_controller_end.sv */
`timescale 1ns/1ps

`include "sram_port_regs.svh"

// Behaviour
// - One word per rising memory clock edge
// - Memory works at any clock below maximum
// - Read data taken two memory clocks later
// - Write data one memory clock after address
// - 512K words of 36 bits each
// - Only one device enabled on shared bus
// - 32 data lines plus four lane parity bits
// - Lane enables, byte gate, whole word write
// - Word address on shared address bits 2..25
// - Drive both output and chip enables, mode
// - Drive both address strobes and advance; processor strobe and advance are held high (idle)
module sram_controller_end
    import sram_port_pkg::*;
#(
    parameter int HALF_CYC = `LINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    shared_memory_bus_if.ctl bus,
    input wire logic bus_grant,
    output logic bus_busy,
    input wire logic burst_order,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`CTL_ADDR_W-1:0] req_addr,
    input wire sram_word_t req_wdata,
    input wire lane_mask_t req_lane_en,
    output logic rsp_valid,
    output sram_word_t rsp_rdata
);

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    // ==========================================================
    // Memory clock divider, 5 MHz from 40 MHz by default
    logic [7:0] half_cnt_r, half_cnt_nxt;
    logic pin_r, pin_nxt;
    logic rise_now, fall_now;

    always_comb begin
        half_cnt_nxt = half_cnt_r + 8'h01;
        pin_nxt = pin_r;
        if (half_cnt_r == HALF_LAST) begin
            half_cnt_nxt = 8'h00;
            pin_nxt = !pin_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            half_cnt_r <= 8'h00;
            pin_r <= 1'b0;
        end else begin
            half_cnt_r <= half_cnt_nxt;
            pin_r <= pin_nxt;
        end
    end

    // Pins change at the falling edge so they are settled at the rise
    assign rise_now = (half_cnt_r == HALF_LAST) & !pin_r;
    assign fall_now = (half_cnt_r == HALF_LAST) & pin_r;
    assign bus.sram_clock_pin = pin_r;

    // ==========================================================
    // Read data synchroniser
    sram_word_t din_s1_r, din_s2_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= {bus.lane_parity_bit, bus.shared_data_line};
            din_s2_r <= din_s1_r;
        end
    end

    // ==========================================================
    // Access sequencer
    ctl_state_t state_r, state_nxt;
    logic [`CTL_ADDR_W-1:0] addr_r, addr_nxt;
    sram_word_t wdata_r, wdata_nxt;
    sram_word_t rdata_r, rdata_nxt;
    logic cs_r, cs_nxt;
    logic strobe_n_r, strobe_n_nxt;
    logic gw_n_r, gw_n_nxt;
    logic bwe_n_r, bwe_n_nxt;
    lane_mask_t bw_n_r, bw_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic dq_oe_n_r, dq_oe_n_nxt;
    logic mode_r, mode_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic start;

    // Bus taken only when granted and only at a falling edge
    assign start = (state_r == ST_IDLE) & fall_now & bus_grant;
    assign req_ready = start;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        cs_nxt = cs_r;
        strobe_n_nxt = strobe_n_r;
        gw_n_nxt = gw_n_r;
        bwe_n_nxt = bwe_n_r;
        bw_n_nxt = bw_n_r;
        oe_n_nxt = oe_n_r;
        dq_oe_n_nxt = dq_oe_n_r;
        mode_nxt = mode_r;
        rsp_valid_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (start && req_valid) begin
                    state_nxt = ST_ADDR;
                    addr_nxt = req_addr;
                    wdata_nxt = req_wdata;
                    cs_nxt = 1'b1;
                    strobe_n_nxt = 1'b0;
                    mode_nxt = burst_order;
                    if (req_write) begin
                        // Full mask uses the whole word write
                        if (req_lane_en == 4'hF) begin
                            gw_n_nxt = 1'b0;
                        end else begin
                            bwe_n_nxt = 1'b0;
                            bw_n_nxt = ~req_lane_en;
                        end
                    end
                end
            end
            ST_ADDR: begin
                if (fall_now) begin
                    strobe_n_nxt = 1'b1;
                    gw_n_nxt = 1'b1;
                    bwe_n_nxt = 1'b1;
                    bw_n_nxt = 4'hF;
                    if (!gw_n_r || !bwe_n_r) begin
                        state_nxt = ST_WDATA;
                        dq_oe_n_nxt = 1'b0;
                    end else begin
                        state_nxt = ST_RWAIT1;
                        oe_n_nxt = 1'b0;
                    end
                end
            end
            ST_WDATA: begin
                // Data held across the edge after the address edge
                if (fall_now) begin
                    state_nxt = ST_IDLE;
                    dq_oe_n_nxt = 1'b1;
                    cs_nxt = 1'b0;
                end
            end
            ST_RWAIT1: begin
                if (fall_now) begin
                    state_nxt = ST_RWAIT2;
                end
            end
            ST_RWAIT2: begin
                if (rise_now) begin
                    state_nxt = ST_REL;
                    rdata_nxt = din_s2_r;
                    rsp_valid_nxt = 1'b1;
                end
            end
            ST_REL: begin
                if (fall_now) begin
                    state_nxt = ST_IDLE;
                    oe_n_nxt = 1'b1;
                    cs_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            cs_r <= 1'b0;
            strobe_n_r <= 1'b1;
            gw_n_r <= 1'b1;
            bwe_n_r <= 1'b1;
            bw_n_r <= 4'hF;
            oe_n_r <= 1'b1;
            dq_oe_n_r <= 1'b1;
            mode_r <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            cs_r <= cs_nxt;
            strobe_n_r <= strobe_n_nxt;
            gw_n_r <= gw_n_nxt;
            bwe_n_r <= bwe_n_nxt;
            bw_n_r <= bw_n_nxt;
            oe_n_r <= oe_n_nxt;
            dq_oe_n_r <= dq_oe_n_nxt;
            mode_r <= mode_nxt;
            rsp_valid_r <= rsp_valid_nxt;
        end
    end

    // ==========================================================
    // Pin drive
    // Bits 0 and 1 of the shared address are left low
    assign bus.shared_address_line = {addr_r, 2'h0};
    assign bus.ctl_data_o = wdata_r[`SRAM_DATA_W-1:0];
    assign bus.ctl_par_o = wdata_r[`SRAM_WORD_W-1:`PAR_LSB];
    assign bus.ctl_data_oe_n = dq_oe_n_r;
    assign bus.output_enable_a_n = oe_n_r;
    assign bus.output_enable_b_n = oe_n_r;
    assign bus.chip_select_high = cs_r;
    assign bus.chip_select_low_n = !cs_r;
    assign bus.burst_order_select = mode_r;
    assign bus.lane_write_enable_n = bw_n_r;
    assign bus.byte_write_gate = bwe_n_r;
    assign bus.whole_word_write_n = gw_n_r;
    // Single accesses only: processor strobe and advance stay idle
    assign bus.controller_addr_strobe_n = strobe_n_r;
    assign bus.processor_addr_strobe_n = 1'b1;
    assign bus.burst_advance_n = 1'b1;
    assign bus_busy = state_r != ST_IDLE;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rdata_r;

endmodule

/* File: test/sram_port_properties.sv */
`timescale 1ns/1ps

`include "sram_port_regs.svh"

module sram_port_properties #(
    parameter int HALF_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sram_clock_pin,
    input wire logic [`BUS_ADDR_W-1:0] shared_address_line,
    input wire logic ctl_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic output_enable_a_n,
    input wire logic output_enable_b_n,
    input wire logic chip_select_high,
    input wire logic chip_select_low_n,
    input wire logic byte_write_gate,
    input wire logic whole_word_write_n,
    input wire logic controller_addr_strobe_n,
    input wire logic processor_addr_strobe_n,
    input wire logic burst_advance_n
);
    localparam int PER = 2 * HALF_CYC;
    localparam int PER1 = 2 * HALF_CYC + 1;
    localparam int PER2 = 4 * HALF_CYC;
    logic prev_r;
    logic seen_r;
    int cnt_r;
    logic wr_addr;
    logic rd_addr;

    // ==========================================================
    // Helper: cycles since the memory clock last moved
    always_ff @(posedge clk_sys) begin
        prev_r <= sram_clock_pin;
        if (sys_rst) begin
            cnt_r <= 0;
            seen_r <= 1'b0;
        end else if (sram_clock_pin != prev_r) begin
            cnt_r <= 0;
            seen_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end

    assign wr_addr = !controller_addr_strobe_n &&
        (!whole_word_write_n || !byte_write_gate);
    assign rd_addr = !controller_addr_strobe_n && whole_word_write_n &&
        byte_write_gate;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Properties
    a_clock_half_period: assert property (
        seen_r && (sram_clock_pin != prev_r) |-> cnt_r == HALF_CYC - 1)
        else $error("memory clock half period wrong");
    a_write_data_lag: assert property (
        $rose(sram_clock_pin) && wr_addr |->
        ##[1:PER] ($rose(sram_clock_pin) && !ctl_data_oe_n))
        else $error("write data missing at next memory edge");
    a_read_data_lag: assert property (
        $rose(sram_clock_pin) && rd_addr |->
        ##[PER1:PER2] ($rose(sram_clock_pin) && !dev_data_oe_n))
        else $error("read data missing two memory edges later");
    a_single_driver: assert property (
        !(!ctl_data_oe_n && !dev_data_oe_n))
        else $error("both ends drive the data lines");
    a_device_gated: assert property (
        $fell(dev_data_oe_n) |-> !output_enable_a_n && !output_enable_b_n)
        else $error("device drove without both output enables");
    a_device_release: assert property (
        $rose(output_enable_a_n) |-> ##[0:4] dev_data_oe_n)
        else $error("device kept driving after output enable");
    a_unused_strobes: assert property (
        processor_addr_strobe_n && burst_advance_n)
        else $error("unused strobe asserted");
    a_word_aligned: assert property (
        !controller_addr_strobe_n |-> shared_address_line[1:0] == 2'b00)
        else $error("address low bits not zero");
    a_select_on_strobe: assert property (
        !controller_addr_strobe_n |-> chip_select_high && !chip_select_low_n)
        else $error("strobe without chip select");
    a_gate_vs_whole: assert property (
        !byte_write_gate |-> whole_word_write_n)
        else $error("byte gate and whole word write together");
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps

module testbench
    import sram_port_pkg::*;
;
    localparam int HALF = 4;
    logic clk_sys, sys_rst, bus_grant, burst_order, req_valid, req_write;
    logic req_ready, bus_busy, rsp_valid, acc_stb, acc_wr, saw;
    logic [23:0] req_addr;
    sram_word_t req_wdata, rsp_rdata;
    lane_mask_t req_lane_en;
    sram_word_t mem [int];
    sram_word_t exp_q [$];
    int error_cnt, cmp_count, n_acc, n_stb, n_wr, n_wr_exp;

    shared_memory_bus_if bus_if ();

    sram_controller_end #(.HALF_CYC(HALF)) u_sram_controller_end (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
        .bus_grant(bus_grant), .bus_busy(bus_busy),
        .burst_order(burst_order), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_lane_en(req_lane_en),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

    sram_device_end u_sram_device_end (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
        .access_strobe(acc_stb), .access_is_write(acc_wr));

    sram_port_properties #(.HALF_CYC(HALF)) u_sram_port_properties (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .sram_clock_pin(bus_if.sram_clock_pin),
        .shared_address_line(bus_if.shared_address_line),
        .ctl_data_oe_n(bus_if.ctl_data_oe_n),
        .dev_data_oe_n(bus_if.dev_data_oe_n),
        .output_enable_a_n(bus_if.output_enable_a_n),
        .output_enable_b_n(bus_if.output_enable_b_n),
        .chip_select_high(bus_if.chip_select_high),
        .chip_select_low_n(bus_if.chip_select_low_n),
        .byte_write_gate(bus_if.byte_write_gate),
        .whole_word_write_n(bus_if.whole_word_write_n),
        .controller_addr_strobe_n(bus_if.controller_addr_strobe_n),
        .processor_addr_strobe_n(bus_if.processor_addr_strobe_n),
        .burst_advance_n(bus_if.burst_advance_n));

    // ==========================================================
    // Clock, compare and verdict
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Read data is compared only when the design says it is there
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(36'h1, 36'h0);
            end else begin
                check(rsp_rdata, exp_q.pop_front());
            end
        end
        if (acc_stb === 1'b1) begin
            n_stb++;
            if (acc_wr === 1'b1) begin
                n_wr++;
            end
        end
    end

    // ==========================================================
    // One access; the shadow copy follows the lane rules
    task automatic access(input logic wr, input logic [23:0] a,
            input sram_word_t d, input lane_mask_t le);
        int k;
        sram_word_t m;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lane_en = le;
        burst_order = 1'($urandom_range(1));
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        @(posedge clk_sys);
        m = mem.exists(int'(a[18:0])) ? mem[int'(a[18:0])] : 'x;
        if (wr) begin
            for (int i = 0; i < 4; i++) begin
                if (le[i]) begin
                    m[8*i+:8] = d[8*i+:8];
                    m[32+i] = d[32+i];
                end
            end
            mem[int'(a[18:0])] = m;
            if (le != 4'h0) begin
                n_wr_exp++;
            end
        end else begin
            exp_q.push_back(m);
        end
        n_acc++;
        @(negedge clk_sys);
        req_valid = 1'b0;
        k = 0;
        while (bus_busy !== 1'b0 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        check(36'(k == 100), 36'h0);
    endtask

    function automatic sram_word_t rnd();
        return {4'($urandom), 32'($urandom)};
    endfunction

    // ==========================================================
    // Tests
    initial begin
        logic [23:0] a;
        sys_rst = 1'b1;
        bus_grant = 1'b1;
        burst_order = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 24'h000000;
        req_wdata = 36'h0;
        req_lane_en = 4'h0;
        error_cnt = 0;
        cmp_count = 0;
        n_acc = 0;
        n_stb = 0;
        n_wr = 0;
        n_wr_exp = 0;
        void'($urandom(34270));
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        // Whole words at both ends of the array and one in between
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 24'h000000 : (i == 1) ? 24'h07FFFF :
                24'($urandom_range(24'h07FFFE, 24'h000001));
            access(1'b1, a, rnd(), 4'hF);
            access(1'b0, a, 36'h0, 4'h0);
        end
        $display("test words done");
        // Every lane mask, parity bit travels with its byte
        access(1'b1, 24'h000100, rnd(), 4'hF);
        for (int l = 0; l < 16; l++) begin
            access(1'b1, 24'h000100, rnd(), 4'(l));
            access(1'b0, 24'h000100, 36'h0, 4'h0);
        end
        $display("test lanes done");
        // Word address bits above the array wrap onto it
        access(1'b1, 24'hF80005, rnd(), 4'hF);
        access(1'b0, 24'h000005, 36'h0, 4'h0);
        $display("test wrap done");
        // No grant: the controller must keep off the shared bus
        @(negedge clk_sys);
        bus_grant = 1'b0;
        req_valid = 1'b1;
        saw = 1'b0;
        repeat (40) begin
            @(negedge clk_sys);
            if (req_ready !== 1'b0 || bus_busy !== 1'b0) saw = 1'b1;
        end
        check(36'(saw), 36'h0);
        req_valid = 1'b0;
        @(negedge clk_sys);
        bus_grant = 1'b1;
        $display("test grant done");
        // Random traffic over a small address set
        for (int i = 0; i < 8; i++) access(1'b1, 24'(i), rnd(), 4'hF);
        for (int i = 0; i < 24; i++) begin
            access(1'($urandom_range(1)), 24'($urandom_range(7)), rnd(),
                4'($urandom_range(15, 1)));
        end
        $display("test random done");
        repeat (8) @(negedge clk_sys);
        check(36'(exp_q.size()), 36'h0);
        check(36'(n_stb), 36'(n_acc));
        check(36'(n_wr), 36'(n_wr_exp));
        results();
    end

    // Roughly 75 accesses of about 30 cycles each; ample margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule
